// File: design/mfcr_regs.v
// Common configuration and diagnostic registers of a four-function board
//
// Contract
// - Only two shared registers: configuration and diagnostic.
// - Bits 15:12 of configuration hold the function-availability code.
// - Valid codes 1000, 1010, 1101, 1110.
// - Parallel port and printer functions never enabled together.
// - Select switches sampled once after power-up to form initial code.
// - Word write to configuration replaces code and low-byte vector; the code keeps its old value when the written code is invalid.
// - Byte write to configuration loads only the vector byte.
// - Bits 11:8 of configuration read zero.
// - Low byte holds base vector, stored as written.
// - Eight vectors derived from base, one step apart.
// - Sixteen-word block located by eight address switches.
// - Word-only registers ignore address bit 0; byte write acts as word.
// - Writing 55 hex forces parity error, LED off, access blocked.
// - Writing AA hex restarts microcode self test from zero.
// - After writing 2A hex, high byte reads revision in BCD.
// - Self-test pass leaves AA hex in diagnostic high byte.
// - Any diagnostic read clears its low byte.
`include "mfcr_defines.vh"
`default_nettype none
module mfcr_regs (
  input  wire        ref_clk,
  input  wire        arst_n,
  input  wire        bus_init,
  input  wire [1:0]  sel_sw,
  input  wire [7:0]  base_sw,
  input  wire [12:0] bus_addr,
  input  wire        bus_wr,
  input  wire        bus_byte,
  input  wire        bus_rd,
  input  wire [15:0] bus_wdata,
  input  wire [7:0]  prn_maint_data,
  input  wire        prn_maint_load,
  output reg  [15:0] bus_rdata,
  output reg         bus_ack,
  output reg         status_led,
  output reg         ucode_run,
  output reg         test_done,
  output reg  [3:0]  func_avail,
  output reg  [63:0] vectors
);
  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation
  wire [1:0]  sel_s;
  wire [7:0]  base_s;
  wire [12:0] addr_s;
  wire [4:0]  ctl_s;
  wire [15:0] wd_s;
  wire        init_s;
  mfcr_sync2 #(.W(1)) u_init (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .d       (bus_init),
    .q       (init_s)
  );
  mfcr_sync2 #(.W(10)) u_sw (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .d       ({sel_sw, base_sw}),
    .q       ({sel_s, base_s})
  );
  mfcr_sync2 #(.W(34)) u_bus (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .d       ({bus_addr, bus_wr, bus_byte, bus_rd, prn_maint_load, 1'b0, bus_wdata}),
    .q       ({addr_s, ctl_s, wd_s})
  );
  wire wr_s    = ctl_s[4];
  wire byte_s  = ctl_s[3];
  wire rd_s    = ctl_s[2];
  wire pload_s = ctl_s[1];

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  reg wr_d_ff;
  reg rd_d_ff;
  wire       wr_p  = wr_s & ~wr_d_ff;
  wire       rd_p  = rd_s & ~rd_d_ff;
  wire       hit   = (addr_s[12:5] == base_s);
  wire [3:0] widx  = addr_s[4:1];
  wire       cfg_h = hit & (widx == `MFCR_CFG_IDX);
  wire       dia_h = hit & (widx == `MFCR_DIAG_IDX);

  function valid_code;
    input [3:0] c;
    begin
      valid_code = (c == `MFCR_CODE_ASYNC) | (c == `MFCR_CODE_ASYNC_PRN) |
                   (c == `MFCR_CODE_ASP)   | (c == `MFCR_CODE_ASPRN);
    end
  endfunction

  function [3:0] sw_code;
    input [1:0] s;
    begin
      case (s)
        2'h0:    sw_code = `MFCR_CODE_ASYNC;
        2'h1:    sw_code = `MFCR_CODE_ASYNC_PRN;
        2'h2:    sw_code = `MFCR_CODE_ASP;
        default: sw_code = `MFCR_CODE_ASPRN;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Microcode state machine
  localparam [2:0] ST_TEST  = 3'h1;
  localparam [2:0] ST_RUN   = 3'h2;
  localparam [2:0] ST_HALT  = 3'h4;
  reg [2:0]  state_ff;
  reg [9:0]  cnt_ff;
  reg        strap_ff;
  reg [3:0]  code_ff;
  reg [7:0]  vec_ff;
  reg [7:0]  dhi_ff;
  reg [7:0]  dlo_ff;
  reg        init_d_ff;
  wire       init_p = init_s & ~init_d_ff;
  wire       acc_ok = (state_ff != ST_HALT);

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff   <= ST_TEST;
      cnt_ff     <= 10'h000;
      strap_ff   <= 1'b0;
      code_ff    <= `MFCR_CODE_ASYNC;
      vec_ff     <= 8'h00;
      dhi_ff     <= 8'h00;
      dlo_ff     <= 8'h00;
      wr_d_ff    <= 1'b0;
      rd_d_ff    <= 1'b0;
      init_d_ff  <= 1'b0;
      bus_rdata  <= 16'h0000;
      bus_ack    <= 1'b0;
      status_led <= 1'b0;
      ucode_run  <= 1'b0;
      test_done  <= 1'b0;
      func_avail <= 4'h0;
      vectors    <= 64'h0;
    end else begin
      wr_d_ff   <= wr_s;
      rd_d_ff   <= rd_s;
      init_d_ff <= init_s;
      bus_ack   <= 1'b0;
      // Wait for the switch synchroniser to settle before the one-time capture
      if (!strap_ff && (cnt_ff == 10'h003)) begin
        strap_ff <= 1'b1;
        code_ff  <= sw_code(sel_s);
      end
      if (pload_s)
        dlo_ff <= prn_maint_data;
      case (state_ff)
        ST_TEST: begin
          if (cnt_ff == (`MFCR_TEST_CYC - 1)) begin
            state_ff <= ST_RUN;
            dhi_ff   <= `MFCR_DIAG_PASS;
          end else begin
            cnt_ff <= cnt_ff + 10'h001;
          end
        end
        ST_RUN: begin
          if (wr_p && acc_ok) begin
            bus_ack <= 1'b1;
            if (cfg_h) begin
              vec_ff <= byte_s ? (addr_s[0] ? wd_s[15:8] : wd_s[7:0]) : wd_s[7:0];
              if (!byte_s && valid_code(wd_s[15:12]))
                code_ff <= wd_s[15:12];
            end else if (dia_h) begin
              if (wd_s[15:8] == `MFCR_DIAG_PARITY) begin
                state_ff <= ST_HALT;
              end else if (wd_s[15:8] == `MFCR_DIAG_RESTART) begin
                state_ff <= ST_TEST;
                cnt_ff   <= 10'h000;
                dhi_ff   <= 8'h00;
              end else if (wd_s[15:8] == `MFCR_DIAG_REV) begin
                dhi_ff <= `MFCR_REV_DEFAULT;
              end else begin
                dhi_ff <= wd_s[15:8];
              end
            end
          end
          if (rd_p && acc_ok && (cfg_h || dia_h)) begin
            bus_ack <= 1'b1;
            if (cfg_h)
              bus_rdata <= {code_ff, 4'h0, vec_ff};
            else begin
              bus_rdata <= {dhi_ff, dlo_ff};
              dlo_ff    <= 8'h00;
            end
          end
        end
        ST_HALT: begin
          if (init_p) begin
            state_ff <= ST_TEST;
            cnt_ff   <= 10'h000;
            dhi_ff   <= 8'h00;
          end
        end
        default: state_ff <= ST_TEST;
      endcase
      if (init_p && state_ff != ST_HALT) begin
        state_ff <= ST_TEST;
        cnt_ff   <= 10'h000;
        dhi_ff   <= 8'h00;
      end
      status_led <= (state_ff != ST_HALT);
      ucode_run  <= (state_ff == ST_RUN);
      test_done  <= (dhi_ff == `MFCR_DIAG_PASS);
      func_avail <= code_ff;
      vectors    <= {vec_ff + 8'h07, vec_ff + 8'h06, vec_ff + 8'h05, vec_ff + 8'h04,
                     vec_ff + 8'h03, vec_ff + 8'h02, vec_ff + `MFCR_VEC_STEP, vec_ff};
    end
  end
endmodule
`default_nettype wire

// File: design/mfcr_defines.vh
// Constants for the multifunction common register bank
`ifndef MFCR_DEFINES_VH
`define MFCR_DEFINES_VH
`define MFCR_WORD_OFS       5'h00
`define MFCR_CFG_IDX        4'h0
`define MFCR_DIAG_IDX       4'h1
`define MFCR_CODE_HI        15
`define MFCR_CODE_LO        12
`define MFCR_CODE_ASYNC     4'h8
`define MFCR_CODE_ASYNC_PRN 4'ha
`define MFCR_CODE_ASP       4'hd
`define MFCR_CODE_ASPRN     4'he
`define MFCR_DIAG_PARITY    8'h55
`define MFCR_DIAG_RESTART   8'haa
`define MFCR_DIAG_REV       8'h2a
`define MFCR_DIAG_PASS      8'haa
`define MFCR_VEC_STEP       8'h01
`define MFCR_REV_DEFAULT    8'h10
`define MFCR_TEST_NS        800
`define MFCR_CLK_NS         8
`define MFCR_TEST_CYC       (`MFCR_TEST_NS / `MFCR_CLK_NS)
`endif

// File: design/mfcr_sync2.v
// Two-stage synchroniser for pin inputs
`default_nettype none
module mfcr_sync2 #(
  parameter W = 1
) (
  input  wire         ref_clk,
  input  wire         arst_n,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta_ff;
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff <= {W{1'b0}};
      q       <= {W{1'b0}};
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule
`default_nettype wire

// File: sim/mfcr_regs_sva.sv
// Assertion checker for the common register bank
`default_nettype none
module mfcr_regs_sva (
  input wire logic        ref_clk,
  input wire logic        arst_n,
  input wire logic        bus_init,
  input wire logic        bus_ack,
  input wire logic        status_led,
  input wire logic        ucode_run,
  input wire logic        test_done,
  input wire logic [3:0]  func_avail,
  input wire logic [63:0] vectors
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////
  a_ack_one_cycle: assert property (bus_ack |=> !bus_ack)
    else $error("ack wider than one cycle");
  a_ack_needs_run: assert property (bus_ack |-> ucode_run && status_led)
    else $error("ack while not running");
  a_halt_stops: assert property (!status_led ##1 !status_led |-> !ucode_run)
    else $error("running while halted");
  a_code_valid: assert property ($past(ucode_run) |-> func_avail inside {4'h8, 4'ha, 4'hd, 4'he})
    else $error("invalid availability code");
  a_vec_chain: assert property (ucode_run |-> vectors[15:8] == vectors[7:0] + 8'h01
    && vectors[63:56] == vectors[7:0] + 8'h07)
    else $error("vector chain broken");
  a_init_restart: assert property ($rose(bus_init) |-> ##[1:8] !ucode_run)
    else $error("init did not restart");
  a_pass_run: assert property ($rose(test_done) |-> ##[0:1] ucode_run)
    else $error("pass without run");
  a_init_led: assert property ($rose(bus_init) |-> ##[1:8] status_led)
    else $error("init left led off");
endmodule
bind mfcr_regs mfcr_regs_sva u_sva (.ref_clk(ref_clk), .arst_n(arst_n), .bus_init(bus_init),
  .bus_ack(bus_ack), .status_led(status_led), .ucode_run(ucode_run), .test_done(test_done),
  .func_avail(func_avail), .vectors(vectors));
`default_nettype wire

// File: sim/mfcr_host.sv
// Host processor model driving single bus cycles
`default_nettype none
module mfcr_host (
  input  wire logic        ref_clk,
  input  wire logic        bus_ack,
  input  wire logic [15:0] bus_rdata,
  output var  logic [12:0] bus_addr = 13'h0000,
  output var  logic        bus_wr = 1'b0,
  output var  logic        bus_rd = 1'b0,
  output var  logic        bus_byte = 1'b0,
  output var  logic [15:0] bus_wdata = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ps;
  // Strobe held until ack or give-up, then a quiet gap
  task automatic xfer(input logic rd, input logic [12:0] a, input logic bt,
                      input logic [15:0] d, output logic ok, output logic [15:0] q);
    ok = 1'b0;
    q = 16'h0000;
    @(posedge ref_clk);
    bus_addr <= a;
    bus_byte <= bt;
    bus_wdata <= d;
    bus_rd <= rd;
    bus_wr <= !rd;
    repeat (12) if (!ok) begin
      @(posedge ref_clk);
      ok = bus_ack;
      q = bus_rdata;
    end
    bus_wr <= 1'b0;
    bus_rd <= 1'b0;
    bus_wdata <= ~d;
    repeat (4) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

// File: sim/mfcr_regs_tb.sv
// Self-checking bench for the common register bank
`default_nettype none
module mfcr_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, arst_n = 1'b0, bus_init = 1'b0, prn_maint_load = 1'b0, ok;
  logic [1:0] sel_sw = 2'b01;
  logic [7:0] sw = 8'h5a, prn_maint_data = 8'h00;
  logic [15:0] q;
  wire logic [12:0] bus_addr;
  wire logic bus_wr, bus_rd, bus_byte, bus_ack, status_led, ucode_run, test_done;
  wire logic [15:0] bus_wdata, bus_rdata;
  wire logic [3:0] func_avail;
  wire logic [63:0] vectors;
  int error_cnt = 0, n_compared = 0;
  always #4 ref_clk = ~ref_clk;
  mfcr_regs uut (.ref_clk(ref_clk), .arst_n(arst_n), .bus_init(bus_init), .sel_sw(sel_sw),
    .base_sw(sw), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_byte(bus_byte), .bus_rd(bus_rd),
    .bus_wdata(bus_wdata), .prn_maint_data(prn_maint_data), .prn_maint_load(prn_maint_load),
    .bus_rdata(bus_rdata), .bus_ack(bus_ack), .status_led(status_led), .ucode_run(ucode_run),
    .test_done(test_done), .func_avail(func_avail), .vectors(vectors));
  mfcr_host host (.ref_clk(ref_clk), .bus_ack(bus_ack), .bus_rdata(bus_rdata),
    .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_byte(bus_byte),
    .bus_wdata(bus_wdata));
  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [4:0] ofs, input logic bt, input logic [15:0] d);
    host.xfer(1'b0, {sw, ofs}, bt, d, ok, q);
  endtask
  task automatic rd(input logic [4:0] ofs, input logic [15:0] exp, input string nm);
    host.xfer(1'b1, {sw, ofs}, 1'b0, 16'h0000, ok, q);
    chk(nm, exp, q);
  endtask
  task automatic run_wait;
    repeat (300) if (!ucode_run) @(posedge ref_clk);
    chk("pass", 16'h0001, {15'h0000, test_done});
  endtask
  task automatic report_and_stop;
    $display("Compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    report_and_stop;
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    run_wait;
    sel_sw <= 2'b11;
    rd(5'h02, 16'haa00, "diag");
    chk("code", 16'h000a, {12'h000, func_avail});
    prn_maint_data <= 8'h5c;
    prn_maint_load <= 1'b1;
    repeat (2) @(posedge ref_clk);
    prn_maint_load <= 1'b0;
    rd(5'h02, 16'haa5c, "maint");
    rd(5'h02, 16'haa00, "clear");
    wr(5'h00, 1'b0, 16'hd0c0);
    rd(5'h00, 16'hd0c0, "cfg");
    chk("vec7", 16'h00c7, {8'h00, vectors[63:56]});
    wr(5'h00, 1'b0, 16'he3a0);
    rd(5'h00, 16'he0a0, "rsvd");
    wr(5'h00, 1'b0, 16'h3011);
    rd(5'h00, 16'he011, "badcode");
    wr(5'h01, 1'b1, 16'h4400);
    rd(5'h00, 16'he044, "hilane");
    wr(5'h00, 1'b1, 16'h0033);
    rd(5'h00, 16'he033, "lolane");
    wr(5'h02, 1'b0, 16'h2a00);
    rd(5'h02, 16'h1000, "rev");
    wr(5'h03, 1'b1, 16'haa00);
    repeat (20) if (ucode_run) @(posedge ref_clk);
    chk("restart", 16'h0000, {15'h0000, ucode_run});
    run_wait;
    host.xfer(1'b1, {~sw, 5'h00}, 1'b0, 16'h0000, ok, q);
    chk("unmapped", 16'h0000, {15'h0000, ok});
    wr(5'h02, 1'b0, 16'h5500);
    chk("led", 16'h0000, {15'h0000, status_led});
    host.xfer(1'b1, {sw, 5'h00}, 1'b0, 16'h0000, ok, q);
    chk("blocked", 16'h0000, {15'h0000, ok});
    bus_init <= 1'b1;
    repeat (8) @(posedge ref_clk);
    bus_init <= 1'b0;
    repeat (8) @(posedge ref_clk);
    run_wait;
    rd(5'h00, 16'he033, "kept");
    bus_init <= 1'b1;
    repeat (8) @(posedge ref_clk);
    bus_init <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk("initrun", 16'h0000, {15'h0000, ucode_run});
    run_wait;
    rd(5'h00, 16'he033, "kept2");
    report_and_stop;
  end
endmodule
`default_nettype wire
